// ---- ims_pkg.sv ----
// Constants, enumerations and carrier types for the instruction-set mode switch
package ims_pkg;

	// ========================================================================
	// Register offsets (byte addresses on the plain register port)
	localparam logic [4:0] REG_CTRL    = 5'h00;
	localparam logic [4:0] REG_CS_BASE = 5'h04;
	localparam logic [4:0] REG_CS_LIM  = 5'h08;
	localparam logic [4:0] REG_STATUS  = 5'h0c;
	localparam logic [4:0] REG_NIP_LO  = 5'h10;
	localparam logic [4:0] REG_NIP_HI  = 5'h14;
	localparam logic [4:0] REG_LIP     = 5'h18;

	// ========================================================================
	// Control register fields
	localparam int CTRL_BLOCK_BIT = 0;
	localparam int CTRL_PE_BIT    = 1;
	localparam int CTRL_VM_BIT    = 2;
	localparam int CTRL_CPL_LSB   = 4;
	localparam int CTRL_DPL_LSB   = 8;

	// Status register fields
	localparam int STAT_IS_BIT    = 0;
	localparam int STAT_MODE_LSB  = 1;
	localparam int STAT_FAULT_LSB = 4;

	// ========================================================================
	// Values after reset
	localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
	localparam logic [31:0] CS_BASE_RST = 32'h0000_0000;
	localparam logic [31:0] CS_LIM_RST  = 32'hffff_ffff;
	localparam logic [63:0] NIP_RST     = 64'h0000_0000_0000_0000;
	localparam logic [31:0] LIP_RST     = 32'h0000_0000;

	// Target alignment mask and the 16-bit operand mask
	localparam logic [31:0] ALIGN_MASK  = 32'hffff_fff0;
	localparam logic [31:0] HALF_MASK   = 32'h0000_ffff;
	localparam logic [1:0]  GP_CODE     = 2'h0;

	// ========================================================================
	// Enumerations
	typedef enum logic [2:0] {
		OP_JUMP_ABS = 3'h0,
		OP_JUMP_IND = 3'h1,
		OP_CROSS    = 3'h2,
		OP_RETURN   = 3'h3,
		OP_INTR     = 3'h4
	} ims_op_type;

	typedef enum logic [1:0] {
		ST_NATIVE = 2'h0,
		ST_REAL   = 2'h1,
		ST_PROT   = 2'h2,
		ST_V86    = 2'h3
	} ims_state_type;

	typedef enum logic [2:0] {
		FLT_NONE      = 3'h0,
		FLT_BLOCKED   = 3'h1,
		FLT_LEGACY_FP = 3'h2,
		FLT_GEN_PROT  = 3'h3,
		FLT_INTERCEPT = 3'h4
	} ims_fault_code_type;

	// ========================================================================
	// Carriers
	typedef struct packed {
		logic        valid;
		ims_op_type  kind;
		logic [31:0] operand;
		logic        wide32;
		logic [63:0] branch_target;
		logic [63:0] resume_ip;
		logic        saved_is;
		logic        saved_pe;
		logic        saved_vm;
		logic        numeric_pending;
	} ims_op_req_type;

	typedef struct packed {
		logic        valid;
		logic [63:0] vaddr;
		logic        sys_res;
		logic        big_endian;
	} ims_ref_req_type;

	typedef struct packed {
		logic        valid;
		logic [63:0] vaddr;
		logic        translate;
		logic        little_endian;
		logic        seg_check;
	} ims_ref_out_type;

	typedef struct packed {
		logic               valid;
		ims_fault_code_type code;
		logic [1:0]         err_code;
	} ims_fault_type;

endpackage : ims_pkg

// ---- ims_mode_switch.sv ----
// Instruction-set mode switch: mode state, transfer targets, faults, addressing
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - One select bit; 1 means legacy instructions run, 0 means native.
// - Every interruption switches to the native instruction set.
// - Return from interruption resumes in the saved instruction set.
// - Native mode: no segment checks, no segment base, addresses virtual.
// - Native mode: full 64-bit addresses, all references translated.
// - Legacy mode: addresses in lowest 4G of region 0, still translated.
// - Legacy mode forces little-endian fetches and data references.
// - Legacy access to superseded system resources raises intercept fault unless a jump, return or interruption is in the same cycle.
// - Switch block bit set makes jump or cross raise a transition fault.
// - Return and interruption switch modes regardless of the block bit.
// - Absolute jump: pointer low half is displacement plus base, high zero.
// - Indirect jump: 16/32-bit register plus base, upper half zero.
// - Jump targets forced 16-byte aligned, within lowest 4G.
// - Pending legacy numeric exception nullifies jump, raises fp fault when the block bit is clear.
// - Switching instruction sets never changes privilege level.
// - Cross copies target low 32 bits, zeroes top; legacy pointer minus base.
// - Legacy pointer over limit or privilege violation gives general protection fault, error code 0.
// - Stack frame registers need not survive legacy execution.
// - Native writes into legacy code stream need not be observed.
// - Cross enters a legacy sub-mode, return does when saved_is is set; jump and interrupt leave.
module ims_mode_switch (
	input  wire logic                     i_clk,
	input  wire logic                     i_rst_n,
	input  wire logic                     i_ce,
	input  wire logic [4:0]               i_addr,
	input  wire logic [31:0]              i_wdata,
	input  wire logic                     i_wr,
	input  wire logic                     i_rd,
	output logic      [31:0]              o_rdata,
	input  wire ims_pkg::ims_op_req_type  i_op,
	input  wire ims_pkg::ims_ref_req_type i_ref,
	output logic                          o_is,
	output ims_pkg::ims_state_type        o_mode,
	output logic      [63:0]              o_nip,
	output logic      [31:0]              o_lip,
	output ims_pkg::ims_fault_type        o_fault,
	output ims_pkg::ims_ref_out_type      o_ref
);

	// ========================================================================
	// Reset release
	logic [1:0] rst_sync_q;
	logic       rst_n;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_q[1];

	// ========================================================================
	// Software registers
	logic [31:0] ctrl_q;
	logic [31:0] cs_base_q;
	logic [31:0] cs_lim_q;
	logic        wr_ctrl;
	logic        block;
	logic [1:0]  cpl;
	logic [1:0]  dpl;

	assign wr_ctrl = i_wr && (i_addr == ims_pkg::REG_CTRL);
	assign block   = ctrl_q[ims_pkg::CTRL_BLOCK_BIT];
	assign cpl     = ctrl_q[ims_pkg::CTRL_CPL_LSB +: 2];
	assign dpl     = ctrl_q[ims_pkg::CTRL_DPL_LSB +: 2];

	// Privilege is only ever written by software, never by a transition
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= ims_pkg::CTRL_RST;
		end else if (i_ce && wr_ctrl) begin
			ctrl_q <= i_wdata;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_base_q <= ims_pkg::CS_BASE_RST;
			cs_lim_q  <= ims_pkg::CS_LIM_RST;
		end else if (i_ce && i_wr) begin
			if (i_addr == ims_pkg::REG_CS_BASE) begin
				cs_base_q <= i_wdata;
			end
			if (i_addr == ims_pkg::REG_CS_LIM) begin
				cs_lim_q <= i_wdata;
			end
		end
	end

	// ========================================================================
	// Transfer decode
	ims_pkg::ims_state_type mode_q;
	ims_pkg::ims_state_type mode_d;
	ims_pkg::ims_state_type entry_mode;
	ims_pkg::ims_state_type resume_mode;
	logic        legacy;
	logic        is_jump;
	logic        is_cross;
	logic [31:0] jump_off;
	logic [31:0] jump_sum;
	logic [31:0] cross_lip;
	logic [63:0] nip_d;
	logic [31:0] lip_d;
	logic        upd_ip;
	ims_pkg::ims_fault_type fault_d;

	assign legacy   = (mode_q != ims_pkg::ST_NATIVE);
	assign is_jump  = i_op.valid && legacy &&
		((i_op.kind == ims_pkg::OP_JUMP_ABS) ||
		 (i_op.kind == ims_pkg::OP_JUMP_IND));
	assign is_cross = i_op.valid && !legacy &&
		(i_op.kind == ims_pkg::OP_CROSS);

	// Both jump forms take a 16- or 32-bit operand, widths agree
	assign jump_off = i_op.wide32 ? i_op.operand
		: (i_op.operand & ims_pkg::HALF_MASK);
	assign jump_sum = (jump_off + cs_base_q)
		& ims_pkg::ALIGN_MASK;
	assign cross_lip = i_op.branch_target[31:0] - cs_base_q;

	// Legacy sub-mode chosen from protection and v86 flags
	function automatic ims_pkg::ims_state_type pick_mode(
		input logic pe,
		input logic vm
	);
		if (!pe) begin
			pick_mode = ims_pkg::ST_REAL;
		end else if (!vm) begin
			pick_mode = ims_pkg::ST_PROT;
		end else begin
			pick_mode = ims_pkg::ST_V86;
		end
	endfunction : pick_mode

	assign entry_mode  = pick_mode(ctrl_q[ims_pkg::CTRL_PE_BIT],
		ctrl_q[ims_pkg::CTRL_VM_BIT]);
	assign resume_mode = pick_mode(i_op.saved_pe, i_op.saved_vm);

	always_comb begin
		mode_d  = mode_q;
		nip_d   = o_nip;
		lip_d   = o_lip;
		upd_ip  = 1'b0;
		fault_d = '{valid: 1'b0, code: ims_pkg::FLT_NONE,
			err_code: 2'h0};
		if (i_op.valid && (i_op.kind == ims_pkg::OP_INTR)) begin
			// Interruption wins over everything and ignores the block bit
			mode_d = ims_pkg::ST_NATIVE;
			nip_d  = i_op.resume_ip;
			upd_ip = 1'b1;
		end else if (i_op.valid && (i_op.kind == ims_pkg::OP_RETURN)) begin
			upd_ip = 1'b1;
			nip_d  = i_op.resume_ip;
			if (i_op.saved_is) begin
				mode_d = resume_mode;
				lip_d  = i_op.resume_ip[31:0] - cs_base_q;
			end else begin
				mode_d = ims_pkg::ST_NATIVE;
			end
		end else if ((is_jump || is_cross) && block) begin
			fault_d.valid = 1'b1;
			fault_d.code  = ims_pkg::FLT_BLOCKED;
		end else if (is_jump && i_op.numeric_pending) begin
			fault_d.valid = 1'b1;
			fault_d.code  = ims_pkg::FLT_LEGACY_FP;
		end else if (is_jump) begin
			mode_d = ims_pkg::ST_NATIVE;
			nip_d  = {32'h0000_0000, jump_sum};
			upd_ip = 1'b1;
		end else if (is_cross) begin
			mode_d = entry_mode;
			nip_d  = {32'h0000_0000, i_op.branch_target[31:0]};
			lip_d  = cross_lip;
			upd_ip = 1'b1;
			// The switch happens; the fault lands on the target instruction
			if ((cross_lip > cs_lim_q) || (cpl > dpl)) begin
				fault_d.valid    = 1'b1;
				fault_d.code     = ims_pkg::FLT_GEN_PROT;
				fault_d.err_code = ims_pkg::GP_CODE;
			end
		end else if (i_ref.valid && legacy && i_ref.sys_res) begin
			fault_d.valid = 1'b1;
			fault_d.code  = ims_pkg::FLT_INTERCEPT;
		end
	end

	// ========================================================================
	// Mode state; stack frame registers and code stream coherence are
	// deliberately left untracked across transitions
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= ims_pkg::ST_NATIVE;
			o_is   <= 1'b0;
			o_mode <= ims_pkg::ST_NATIVE;
		end else if (i_ce) begin
			mode_q <= mode_d;
			o_is   <= (mode_d != ims_pkg::ST_NATIVE);
			o_mode <= mode_d;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_nip <= ims_pkg::NIP_RST;
			o_lip <= ims_pkg::LIP_RST;
		end else if (i_ce && upd_ip) begin
			o_nip <= nip_d;
			o_lip <= lip_d;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_fault <= '{valid: 1'b0, code: ims_pkg::FLT_NONE,
				err_code: 2'h0};
		end else if (i_ce) begin
			o_fault <= fault_d;
		end
	end

	// ========================================================================
	// Address path; every reference except a legacy superseded-resource access goes to translation
	ims_pkg::ims_ref_out_type ref_d;

	always_comb begin
		ref_d.valid     = i_ref.valid && !(legacy && i_ref.sys_res);
		ref_d.translate = 1'b1;
		if (legacy) begin
			ref_d.vaddr = {32'h0000_0000,
				i_ref.vaddr[31:0] + cs_base_q};
			ref_d.little_endian = 1'b1;
			ref_d.seg_check     = 1'b1;
		end else begin
			ref_d.vaddr         = i_ref.vaddr;
			ref_d.little_endian = !i_ref.big_endian;
			ref_d.seg_check     = 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_ref <= '0;
		end else if (i_ce) begin
			o_ref <= ref_d;
		end
	end

	// ========================================================================
	// Read port
	logic [31:0] rdata_d;
	logic [31:0] status;

	assign status = {25'h0, o_fault.code, 1'b0, o_mode, o_is};

	always_comb begin
		case (i_addr)
			ims_pkg::REG_CTRL:    rdata_d = ctrl_q;
			ims_pkg::REG_CS_BASE: rdata_d = cs_base_q;
			ims_pkg::REG_CS_LIM:  rdata_d = cs_lim_q;
			ims_pkg::REG_STATUS:  rdata_d = status;
			ims_pkg::REG_NIP_LO:  rdata_d = o_nip[31:0];
			ims_pkg::REG_NIP_HI:  rdata_d = o_nip[63:32];
			ims_pkg::REG_LIP:     rdata_d = o_lip;
			default:              rdata_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_rdata <= 32'h0000_0000;
		end else if (i_ce) begin
			o_rdata <= i_rd ? rdata_d : 32'h0000_0000;
		end
	end

	// ========================================================================
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!rst_n);

	sequence s_op(ims_pkg::ims_op_type k);
		i_ce && i_op.valid && (i_op.kind == k);
	endsequence

	sequence s_cross_go;
		s_op(ims_pkg::OP_CROSS) ##0 (!legacy && !block);
	endsequence

	sequence s_jump_go;
		i_ce && is_jump && !block && !i_op.numeric_pending;
	endsequence

	a_intr_native: assert property (
		s_op(ims_pkg::OP_INTR) |=> !o_is && (o_mode == ims_pkg::ST_NATIVE))
		else $error("interruption did not return to native");

	a_return_saved: assert property (
		s_op(ims_pkg::OP_RETURN) |=> (o_is == $past(i_op.saved_is)))
		else $error("return did not restore saved instruction set");

	a_block_fault: assert property (
		(i_ce && (is_jump || is_cross) && block
			&& !(i_op.kind inside {ims_pkg::OP_INTR, ims_pkg::OP_RETURN}))
		|=> o_fault.valid && (o_fault.code == ims_pkg::FLT_BLOCKED)
			&& $stable(o_mode))
		else $error("blocked transition was not refused");

	a_jump_align: assert property (
		s_jump_go |=> (o_nip[3:0] == 4'h0) && (o_nip[63:32] == 32'h0)
			&& !o_is)
		else $error("jump target not aligned low native");

	a_fp_nullify: assert property (
		(i_ce && is_jump && !block && i_op.numeric_pending)
		|=> o_is && (o_fault.code == ims_pkg::FLT_LEGACY_FP))
		else $error("pending numeric exception did not nullify jump");

	a_cross_ptr: assert property (
		s_cross_go |=> o_is && (o_nip == {32'h0,
			$past(i_op.branch_target[31:0])})
			&& (o_lip == o_nip[31:0] - $past(cs_base_q)))
		else $error("cross target pointer wrong");

	a_cross_mode: assert property (
		s_cross_go ##0 (ctrl_q[ims_pkg::CTRL_PE_BIT]
			&& !ctrl_q[ims_pkg::CTRL_VM_BIT])
		|=> (o_mode == ims_pkg::ST_PROT))
		else $error("protected sub-mode not selected");

	a_priv_keep: assert property (
		(i_ce && i_op.valid && !wr_ctrl) |=> $stable(cpl))
		else $error("transition changed privilege level");

	a_legacy_endian: assert property (
		(i_ce && i_ref.valid && legacy && !i_ref.sys_res)
		|=> o_ref.valid && o_ref.little_endian)
		else $error("legacy reference not little-endian");

	a_legacy_low: assert property (
		(i_ce && i_ref.valid && legacy)
		|=> (o_ref.vaddr[63:32] == 32'h0) && o_ref.translate)
		else $error("legacy address outside lowest 4G");

	a_native_flat: assert property (
		(i_ce && i_ref.valid && !legacy)
		|=> (o_ref.vaddr == $past(i_ref.vaddr)) && !o_ref.seg_check)
		else $error("native address altered by segmentation");

	a_intercept: assert property (
		(i_ce && i_ref.valid && legacy && i_ref.sys_res && !i_op.valid)
		|=> o_fault.valid && (o_fault.code == ims_pkg::FLT_INTERCEPT)
			&& !o_ref.valid)
		else $error("superseded resource access not intercepted");

endmodule : ims_mode_switch

`default_nettype wire

// ---- tb.sv ----
// Self-checking testbench for the instruction-set mode switch
`timescale 1ns/1ps
`default_nettype none
module tb;
	// ========================================================================
	// Design hookup
	logic                     i_clk;
	logic                     i_rst_n;
	logic                     i_ce;
	logic [4:0]               i_addr;
	logic [31:0]              i_wdata;
	logic                     i_wr;
	logic                     i_rd;
	logic [31:0]              o_rdata;
	ims_pkg::ims_op_req_type  i_op;
	ims_pkg::ims_ref_req_type i_ref;
	logic                     o_is;
	ims_pkg::ims_state_type   o_mode;
	logic [63:0]              o_nip;
	logic [31:0]              o_lip;
	ims_pkg::ims_fault_type   o_fault;
	ims_pkg::ims_ref_out_type o_ref;
	int                       err_count;
	int                       n_tests;
	int                       i;
	// Entry flags per pass: cpl 2, dpl 3, then pe and vm combinations
	logic [31:0]              ctl_tab [3] = '{32'h320, 32'h322, 32'h326};
	ims_pkg::ims_state_type   md_tab [3] = '{ims_pkg::ST_REAL,
		ims_pkg::ST_PROT, ims_pkg::ST_V86};
	ims_pkg::ims_op_type      jk_tab [3] = '{ims_pkg::OP_JUMP_ABS,
		ims_pkg::OP_JUMP_ABS, ims_pkg::OP_JUMP_IND};
	logic [31:0]              jo_tab [3] = '{32'h5677, 32'hffff_ff80,
		32'habcd_9999};
	logic                     jw_tab [3] = '{1'b1, 1'b1, 1'b0};
	logic [63:0]              jn_tab [3] = '{64'h5770, 64'h80, 64'h9a90};

	ims_mode_switch dut_u (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_ce    (i_ce),
		.i_addr  (i_addr),
		.i_wdata (i_wdata),
		.i_wr    (i_wr),
		.i_rd    (i_rd),
		.o_rdata (o_rdata),
		.i_op    (i_op),
		.i_ref   (i_ref),
		.o_is    (o_is),
		.o_mode  (o_mode),
		.o_nip   (o_nip),
		.o_lip   (o_lip),
		.o_fault (o_fault),
		.o_ref   (o_ref)
	);

	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end

	// ========================================================================
	// Access tasks
	task chk(input string nm, input logic [63:0] seen, input logic [63:0] ex);
		n_tests++;
		if (seen !== ex) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, ex, seen);
		end
	endtask : chk

	task wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr

	task rd(input logic [4:0] a, input logic [31:0] ex);
		@(posedge i_clk);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		chk("rdata", o_rdata, ex);
	endtask : rd

	task op(input ims_pkg::ims_op_type k, input logic [63:0] v,
		input logic w, input logic [2:0] sv, input logic np);
		ims_pkg::ims_op_req_type r;
		r = '0;
		r.valid = 1'b1;
		r.kind = k;
		r.operand = v[31:0];
		r.wide32 = w;
		r.branch_target = v;
		r.resume_ip = v;
		{r.saved_is, r.saved_pe, r.saved_vm} = sv;
		r.numeric_pending = np;
		@(posedge i_clk);
		i_op <= r;
		@(posedge i_clk);
		i_op <= '0;
		#1;
	endtask : op

	task rf(input logic [63:0] va, input logic sys, input logic be);
		@(posedge i_clk);
		i_ref <= '{1'b1, va, sys, be};
		@(posedge i_clk);
		i_ref <= '0;
		#1;
	endtask : rf

	task st(input logic is, input ims_pkg::ims_state_type md,
		input logic [63:0] nip, input logic [2:0] fc);
		chk("is", o_is, is);
		chk("mode", o_mode, md);
		chk("nip", o_nip, nip);
		chk("fault", {o_fault.valid, o_fault.code, o_fault.err_code},
			{fc != 3'h0, fc, 2'h0});
	endtask : st

	task done(input string nm);
		$display("test %s finished", nm);
	endtask : done

	task wrap_up;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : wrap_up

	// Hang guard
	initial begin
		repeat (5000) @(posedge i_clk);
		err_count++;
		wrap_up;
	end

	// ========================================================================
	// Main sequence
	initial begin
		err_count = 0;
		n_tests = 0;
		i_rst_n = 1'b0;
		i_ce = 1'b1;
		i_addr = 5'h00;
		i_wdata = 32'h0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_op = '0;
		i_ref = '0;
		repeat (3) @(posedge i_clk);
		i_rst_n <= 1'b1;
		repeat (4) @(posedge i_clk);
		#1;
		st(1'b0, ims_pkg::ST_NATIVE, 64'h0, 3'h0);
		rd(ims_pkg::REG_CS_LIM, 32'hffff_ffff);
		rd(ims_pkg::REG_CTRL, 32'h0);
		wr(5'h1c, 32'h1234_5678);
		rd(5'h1c, 32'h0);
		wr(ims_pkg::REG_CS_BASE, 32'h100);
		rd(ims_pkg::REG_CS_BASE, 32'h100);
		rf(64'hffff_0000_8000_0040, 1'b1, 1'b1);
		chk("ref", {o_ref.valid, o_ref.vaddr, o_ref.translate},
			{1'b1, 64'hffff_0000_8000_0040, 1'b1});
		chk("seg", {o_ref.seg_check, o_fault.valid}, 2'h0);
		done("reset and native refs");
		for (i = 0; i < 3; i++) begin
			wr(ims_pkg::REG_CTRL, ctl_tab[i]);
			op(ims_pkg::OP_CROSS, 64'hdead_beef_1234_5678, 1'b0, 3'h0, 1'b0);
			st(1'b1, md_tab[i], 64'h1234_5678, 3'h0);
			chk("lip", o_lip, 32'h1234_5578);
			rd(ims_pkg::REG_CTRL, ctl_tab[i]);
			if (i == 0) begin
				rd(ims_pkg::REG_NIP_HI, 32'h0);
				rd(ims_pkg::REG_LIP, 32'h1234_5578);
				rf(64'hffff_0000_8000_0040, 1'b0, 1'b1);
				chk("ref", {o_ref.valid, o_ref.vaddr, o_ref.translate},
					{1'b1, 64'h8000_0140, 1'b1});
				chk("le", o_ref.little_endian, 1'b1);
				chk("segl", o_ref.seg_check, 1'b1);
				rf(64'h40, 1'b1, 1'b0);
				chk("icpt", {o_ref.valid, o_fault.valid, o_fault.code},
					{2'b01, ims_pkg::FLT_INTERCEPT});
			end
			op(jk_tab[i], {32'h0, jo_tab[i]}, jw_tab[i], 3'h0, 1'b0);
			st(1'b0, ims_pkg::ST_NATIVE, jn_tab[i], 3'h0);
			rd(ims_pkg::REG_CTRL, ctl_tab[i]);
		end
		done("cross and jump");
		wr(ims_pkg::REG_CTRL, 32'h322);
		op(ims_pkg::OP_CROSS, 64'h600, 1'b0, 3'h0, 1'b0);
		op(ims_pkg::OP_JUMP_ABS, 64'h40, 1'b1, 3'h0, 1'b1);
		st(1'b1, ims_pkg::ST_PROT, 64'h600, 3'h2);
		rd(ims_pkg::REG_STATUS, 32'h5);
		op(ims_pkg::OP_INTR, 64'h8000_0000_0000_1000, 1'b0, 3'h0, 1'b0);
		st(1'b0, ims_pkg::ST_NATIVE, 64'h8000_0000_0000_1000, 3'h0);
		done("numeric pending and interrupt");
		wr(ims_pkg::REG_CTRL, 32'h323);
		op(ims_pkg::OP_CROSS, 64'h700, 1'b0, 3'h0, 1'b0);
		st(1'b0, ims_pkg::ST_NATIVE, 64'h8000_0000_0000_1000, 3'h1);
		op(ims_pkg::OP_RETURN, 64'h3000, 1'b0, 3'h7, 1'b0);
		st(1'b1, ims_pkg::ST_V86, 64'h3000, 3'h0);
		chk("lip", o_lip, 32'h2f00);
		op(ims_pkg::OP_JUMP_ABS, 64'h40, 1'b1, 3'h0, 1'b0);
		st(1'b1, ims_pkg::ST_V86, 64'h3000, 3'h1);
		op(ims_pkg::OP_INTR, 64'h4000, 1'b0, 3'h0, 1'b0);
		st(1'b0, ims_pkg::ST_NATIVE, 64'h4000, 3'h0);
		op(ims_pkg::OP_RETURN, 64'h5000, 1'b0, 3'h3, 1'b0);
		st(1'b0, ims_pkg::ST_NATIVE, 64'h5000, 3'h0);
		done("transition block");
		wr(ims_pkg::REG_CTRL, 32'h320);
		wr(ims_pkg::REG_CS_LIM, 32'h1000);
		op(ims_pkg::OP_CROSS, 64'h2100, 1'b0, 3'h0, 1'b0);
		st(1'b1, ims_pkg::ST_REAL, 64'h2100, 3'h3);
		op(ims_pkg::OP_INTR, 64'h6000, 1'b0, 3'h0, 1'b0);
		op(ims_pkg::OP_CROSS, 64'h200, 1'b0, 3'h0, 1'b0);
		st(1'b1, ims_pkg::ST_REAL, 64'h200, 3'h0);
		op(ims_pkg::OP_INTR, 64'h6000, 1'b0, 3'h0, 1'b0);
		wr(ims_pkg::REG_CTRL, 32'h030);
		op(ims_pkg::OP_CROSS, 64'h200, 1'b0, 3'h0, 1'b0);
		st(1'b1, ims_pkg::ST_REAL, 64'h200, 3'h3);
		rd(ims_pkg::REG_LIP, 32'h100);
		// Clock enable low: an interruption must leave all state frozen
		@(posedge i_clk);
		i_ce <= 1'b0;
		op(ims_pkg::OP_INTR, 64'h7000, 1'b0, 3'h0, 1'b0);
		st(1'b1, ims_pkg::ST_REAL, 64'h200, 3'h0);
		@(posedge i_clk);
		i_ce <= 1'b1;
		done("general protection");
		wrap_up;
	end
endmodule : tb
`default_nettype wire
